// ---- dv/term_panel.sv ----
// Pushbutton and switch model driving the intelligent input terminals.
`timescale 1ns/1ns
`default_nettype none
module term_panel
  import seq_pkg::*;
(
  input wire logic i_clk, // Control clock.
  output logic [NUM_TERM-1:0] o_term, // Terminal contact levels.
  output logic o_fwd, // Forward run switch.
  output logic o_rev // Reverse run switch.
);
  initial begin
    o_term = '0;
    o_fwd = 1'b0;
    o_rev = 1'b0;
  end

  // A contact may chatter before it settles, so the sequencer must act on the settled level only.
  task automatic set_lines(input logic [NUM_TERM-1:0] t, input logic f, input logic r,
                           input bit bounce);
    logic [NUM_TERM+1:0] old_v;
    old_v = {r ^ o_rev, f ^ o_fwd, t ^ o_term} ^ {r, f, t};
    if (bounce) begin
      for (int i = 0; i < 6; i++) begin
        @(posedge i_clk);
        {o_rev, o_fwd, o_term} <= (i % 2 == 0) ? {r, f, t} : old_v;
        repeat (9) @(posedge i_clk);
      end
    end
    @(posedge i_clk);
    {o_rev, o_fwd, o_term} <= {r, f, t};
  endtask : set_lines
endmodule : term_panel
`default_nettype wire

// ---- dv/test_drive_start_inch_seq.sv ----
// Self-checking bench for the run command sequencer.
`timescale 1ns/1ns
`default_nettype none
module test_drive_start_inch_seq
  import seq_pkg::*;
;
  localparam int SETTLE = 300;
  localparam logic [9:0] START_F = 10'h064;
  localparam logic [9:0] INCH_F = 10'h3e7;
  localparam logic [9:0] RUN_F = 10'h2bc;
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic run, dir, inch, free_run, decel_stop, dc_brake, auto_boost, fwd, rev;
  logic [9:0] freq;
  logic [7:0] volt;
  logic [NUM_TERM-1:0] term;
  int n_errors = 0;
  int n_tests = 0;

  drive_start_inch_seq #(.P_RAMP_UNIT_CYC(512)) dut_u (.I_CLK(clk), .I_RST(rst),
    .I_TERM(term), .I_FWD(fwd), .I_REV(rev), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_RUN(run), .O_DIR(dir),
    .O_INCH(inch), .O_FREQ(freq), .O_VOLT(volt), .O_FREE_RUN(free_run),
    .O_DECEL_STOP(decel_stop), .O_DC_BRAKE(dc_brake), .O_AUTO_BOOST(auto_boost));
  term_panel panel_u (.i_clk(clk), .o_term(term), .o_fwd(fwd), .o_rev(rev));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready_wait", 32'h1, 32'h0);
      finish_test();
    end else begin
      @(posedge clk);
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, a, wd, d, e);
    chk("write_err", 32'h0, {31'h0, e});
  endtask : wr

  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk(what, exp, d);
    chk("read_err", 32'h0, {31'h0, e});
  endtask : rdc

  task automatic cfg(input logic [39:0] fns, input logic [7:0] src, input logic [7:0] mode,
                     input logic [7:0] ramp);
    wr(ADDR_TERM_A, fns[31:0]);
    wr(ADDR_TERM_B, {16'h0, src, fns[39:32]});
    wr(ADDR_MODE, {8'h0, ramp, 8'h00, mode});
  endtask : cfg

  task automatic wait_on(input bit sel_inch, input logic v, output logic [9:0] f0);
    for (int n = 0; n < 600; n++) begin
      @(posedge clk);
      if ((sel_inch ? inch : run) === v) begin
        f0 = freq;
        return;
      end
    end
    chk(sel_inch ? "inch_wait" : "run_wait", {31'h0, v}, 32'hffffffff);
    finish_test();
  endtask : wait_on

  task automatic settle(input logic [NUM_TERM-1:0] t, input logic f, input logic r);
    panel_u.set_lines(t, f, r, 1'b0);
    repeat (SETTLE) @(posedge clk);
  endtask : settle

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic e;
    rdc("freq_reset", ADDR_FREQ, {6'h0, RST_INCH_F, 6'h0, RST_INIT_F});
    rdc("runf_reset", ADDR_RUNF, {22'h0, RST_RUN_F});
    wr(ADDR_STATUS, 32'hffffffff);
    rdc("status_ro", ADDR_STATUS, 32'h0);
    rdc("out_idle", ADDR_OUT, 32'h0);
    apb(1'b0, 12'h01c, 32'h0, d, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, d);
    wr(ADDR_MODE, {16'h0, BOOST_AUTO, 8'h00});
    repeat (2) @(posedge clk);
    chk("auto_boost", 32'h1, {31'h0, auto_boost});
    wr(ADDR_MODE, 32'h0);
    repeat (2) @(posedge clk);
    chk("manual_boost", 32'h0, {31'h0, auto_boost});
    wr(ADDR_FREQ, {6'h0, INCH_F, 6'h0, START_F});
    wr(ADDR_RUNF, {22'h0, RUN_F});
    rdc("freq_back", ADDR_FREQ, {6'h0, INCH_F, 6'h0, START_F});
    $display("test regs done");
  endtask : t_regs

  task automatic t_three_wire;
    logic [9:0] f0;
    cfg({16'h0, FN_DIR, FN_STOP, FN_START}, 8'h00, 8'h00, RAMP_OFF);
    settle(5'b00010, 1'b0, 1'b0);
    settle(5'b00011, 1'b0, 1'b0);
    chk("start_wrong_source", 32'h0, {31'h0, run});
    wr(ADDR_TERM_B, {16'h0, SRC_TERMINAL, 8'h00});
    settle(5'b00000, 1'b0, 1'b0);
    settle(5'b00001, 1'b0, 1'b0);
    chk("start_without_stop", 32'h0, {31'h0, run});
    settle(5'b00110, 1'b0, 1'b0);
    panel_u.set_lines(5'b00111, 1'b0, 1'b0, 1'b1);
    chk("bounce_ignored", 32'h0, {31'h0, run});
    wait_on(1'b0, 1'b1, f0);
    chk("first_freq", {22'h0, START_F}, {22'h0, f0});
    chk("latched_dir", 32'h1, {31'h0, dir});
    settle(5'b00110, 1'b0, 1'b0);
    chk("latched_run", 32'h1, {31'h0, run});
    chk("run_freq", {22'h0, RUN_F}, {22'h0, freq});
    panel_u.set_lines(5'b00100, 1'b0, 1'b0, 1'b0);
    wait_on(1'b0, 1'b0, f0);
    chk("stop_decel", 32'h1, {31'h0, decel_stop});
    settle(5'b00010, 1'b1, 1'b1);
    chk("run_inputs_ignored", 32'h0, {31'h0, run});
    settle(5'b00000, 1'b0, 1'b0);
    $display("test three_wire done");
  endtask : t_three_wire

  task automatic t_ramp;
    logic [9:0] f0;
    int n;
    cfg(40'h0, SRC_TERMINAL, 8'h00, 8'h01);
    panel_u.set_lines(5'b00000, 1'b1, 1'b0, 1'b0);
    wait_on(1'b0, 1'b1, f0);
    chk("volt_ramping", 32'h1, {31'h0, volt < VOLT_FULL});
    for (n = 0; n < 1000 && volt !== VOLT_FULL; n++) @(posedge clk);
    chk("ramp_span", 32'h1, {31'h0, n > 256 && n < 1000});
    settle(5'b00000, 1'b0, 1'b0);
    wr(ADDR_MODE, 32'h0);
    panel_u.set_lines(5'b00000, 1'b0, 1'b1, 1'b0);
    wait_on(1'b0, 1'b1, f0);
    repeat (2) @(posedge clk);
    chk("volt_no_ramp", {24'h0, VOLT_FULL}, {24'h0, volt});
    chk("reverse_dir", 32'h1, {31'h0, dir});
    settle(5'b00000, 1'b0, 1'b0);
    $display("test ramp done");
  endtask : t_ramp

  task automatic t_inch;
    logic [9:0] f0;
    for (int m = 0; m < 6; m++) begin
      cfg({8'h0, FN_INCH, 24'h0}, SRC_TERMINAL, 8'(m), RAMP_OFF);
      settle(5'b01000, 1'b0, 1'b0);
      panel_u.set_lines(5'b01000, 1'b1, 1'b0, 1'b1);
      wait_on(1'b1, 1'b1, f0);
      chk("inch_first_freq", {22'h0, START_F}, {22'h0, f0});
      repeat (4) @(posedge clk);
      chk("inch_freq", {22'h0, INCH_F}, {22'h0, freq});
      panel_u.set_lines(5'b01000, 1'b0, 1'b0, 1'b0);
      wait_on(1'b0, 1'b0, f0);
      chk("stop_kind", {29'h0, 3'b001 << (m % 3)},
          {29'h0, dc_brake, decel_stop, free_run});
      settle(5'b00000, 1'b0, 1'b0);
      panel_u.set_lines(5'b00000, 1'b1, 1'b0, 1'b0);
      wait_on(1'b0, 1'b1, f0);
      settle(5'b01000, 1'b1, 1'b0);
      chk("inch_after_run", {31'h0, m > 2}, {31'h0, inch});
      settle(5'b00000, 1'b1, 1'b0);
      if (m > 2) begin
        chk("inch_drop_run", 32'h0, {31'h0, run});
        chk("inch_drop_free", 32'h1, {31'h0, free_run});
      end
      settle(5'b00000, 1'b0, 1'b0);
    end
    $display("test inch done");
  endtask : t_inch

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_three_wire();
    t_ramp();
    t_inch();
    finish_test();
  end
endmodule : test_drive_start_inch_seq
`default_nettype wire

// ---- logic/drive_start_inch_seq.sv ----
// Run command sequencer: three-wire start, start frequency, soft ramp and inch.
`timescale 1ns/1ns
`default_nettype none
module drive_start_inch_seq
  import seq_pkg::*;
#(
  parameter int P_RAMP_UNIT_CYC = RAMP_UNIT_CYC
) (
  input wire logic I_CLK, // Control clock, 125 MHz.
  input wire logic I_RST, // Synchronous reset, active high.
  input wire logic [NUM_TERM-1:0] I_TERM, // Intelligent input terminals.
  input wire logic I_FWD, // Forward run input.
  input wire logic I_REV, // Reverse run input.
  input wire logic I_PSEL, // APB select.
  input wire logic I_PENABLE, // APB enable.
  input wire logic I_PWRITE, // APB write.
  input wire logic [11:0] I_PADDR, // APB byte address.
  input wire logic [31:0] I_PWDATA, // APB write data.
  input wire logic [3:0] I_PSTRB, // APB byte strobes.
  output logic [31:0] O_PRDATA, // APB read data.
  output logic O_PREADY, // APB ready.
  output logic O_PSLVERR, // APB error on unmapped address.
  output logic O_RUN, // Motor commanded to run.
  output logic O_DIR, // Direction, high is reverse.
  output logic O_INCH, // Inch operation active.
  output logic [9:0] O_FREQ, // Output frequency, 0.01 Hz units.
  output logic [7:0] O_VOLT, // Output voltage scale, full is 8'hff.
  output logic O_FREE_RUN, // Last stop was free run.
  output logic O_DECEL_STOP, // Last stop was decelerated.
  output logic O_DC_BRAKE, // Last stop uses DC braking.
  output logic O_AUTO_BOOST // Automatic boost selected.
);
  localparam int SUB_CYC = (P_RAMP_UNIT_CYC >= RAMP_STEPS) ? P_RAMP_UNIT_CYC / RAMP_STEPS : 1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic term_hit(input logic [NUM_TERM-1:0][7:0] fn,
                                    input logic [7:0] code,
                                    input logic [NUM_TERM-1:0] lvl);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      hit = hit | (fn[i] == code && lvl[i]);
    end
    return hit;
  endfunction : term_hit

  function automatic logic [9:0] clamp_freq(input logic [9:0] f, input logic [9:0] lo);
    logic [9:0] r;
    r = (f < lo) ? lo : f;
    return (r > FREQ_MAX) ? FREQ_MAX : r;
  endfunction : clamp_freq

  function automatic stop_t stop_kind(input logic [7:0] mode);
    unique case (mode)
      MODE_DECEL_LO, MODE_DECEL_HI: return STOP_DECEL;
      MODE_DCB_LO, MODE_DCB_HI: return STOP_DCB;
      default: return STOP_FREE;
    endcase
  endfunction : stop_kind

  // ----------------------------------------------------------------
  // Input synchroniser and debounce
  // ----------------------------------------------------------------
  logic [NUM_IN-1:0] sync1_r, sync2_r, clean_r, clean_nxt;
  logic [NUM_IN-1:0][7:0] deb_r, deb_nxt;

  // Debounce makes jog and forward ordering independent of contact bounce.
  always_comb begin
    clean_nxt = clean_r;
    deb_nxt = deb_r;
    for (int i = 0; i < NUM_IN; i++) begin
      if (sync2_r[i] == clean_r[i]) begin
        deb_nxt[i] = 8'h00;
      end else if (deb_r[i] == 8'(DEB_CYC - 1)) begin
        deb_nxt[i] = 8'h00;
        clean_nxt[i] = sync2_r[i]; // see R17
      end else begin
        deb_nxt[i] = deb_r[i] + 8'h01;
      end
    end
  end
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      sync1_r <= '0;
      sync2_r <= '0;
      clean_r <= '0;
      deb_r <= '0;
    end else begin
      sync1_r <= {I_REV, I_FWD, I_TERM};
      sync2_r <= sync1_r;
      clean_r <= clean_nxt;
      deb_r <= deb_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register file on APB
  // ----------------------------------------------------------------
  cfg_t cfg_r, cfg_nxt;
  logic [31:0] prdata_nxt, rd_word, wr_word;
  logic pready_nxt, pslverr_nxt, mapped, access;
  state_t state_r, state_nxt;
  stop_t stop_r, stop_nxt;
  logic dir_r, stop_asg;
  logic [9:0] freq_r;
  logic [7:0] volt_r;
  always_comb begin
    mapped = 1'b1;
    unique case (I_PADDR)
      ADDR_TERM_A: rd_word = cfg_r.term_fn[3:0];
      ADDR_TERM_B: rd_word = {16'h0000, cfg_r.run_src, cfg_r.term_fn[4]};
      ADDR_MODE: rd_word = {8'h00, cfg_r.ramp_sel, cfg_r.boost, cfg_r.inch_mode};
      ADDR_FREQ: rd_word = {6'h00, cfg_r.inch_freq, 6'h00, cfg_r.init_freq};
      ADDR_STATUS: rd_word = {16'h0000, volt_r, 1'b0, stop_asg, stop_r == STOP_DCB,
                              stop_r == STOP_DECEL, stop_r == STOP_FREE,
                              state_r == ST_INCH, dir_r, state_r != ST_IDLE};
      ADDR_OUT: rd_word = {9'h000, clean_r, 6'h00, freq_r};
      ADDR_RUNF: rd_word = {22'h000000, cfg_r.run_freq};
      default: begin
        rd_word = 32'h0000_0000;
        mapped = 1'b0;
      end
    endcase
    for (int b = 0; b < 4; b++) begin
      wr_word[b*8 +: 8] = I_PSTRB[b] ? I_PWDATA[b*8 +: 8] : rd_word[b*8 +: 8];
    end
    // One wait state: ready rises in the second access cycle.
    access = I_PSEL && I_PENABLE && O_PREADY;
    pready_nxt = I_PSEL && I_PENABLE && !O_PREADY;
    prdata_nxt = (pready_nxt && !I_PWRITE) ? rd_word : 32'h0000_0000;
    pslverr_nxt = pready_nxt && !mapped;
    cfg_nxt = cfg_r;
    if (access && I_PWRITE) begin
      unique case (I_PADDR)
        ADDR_TERM_A: cfg_nxt.term_fn[3:0] = wr_word;
        ADDR_TERM_B: begin
          cfg_nxt.term_fn[4] = wr_word[7:0];
          cfg_nxt.run_src = wr_word[POS_RUN_SRC +: 8];
        end
        ADDR_MODE: begin
          cfg_nxt.inch_mode = wr_word[7:0];
          cfg_nxt.boost = wr_word[POS_BOOST +: 8];
          cfg_nxt.ramp_sel = wr_word[POS_RAMP +: 8];
        end
        ADDR_FREQ: begin
          cfg_nxt.init_freq = wr_word[9:0];
          cfg_nxt.inch_freq = wr_word[POS_INCH_F +: 10];
        end
        ADDR_RUNF: cfg_nxt.run_freq = wr_word[9:0];
        default: cfg_nxt = cfg_r;
      endcase
    end
  end
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      cfg_r <= RST_CFG;
      O_PRDATA <= 32'h0000_0000;
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      O_PRDATA <= prdata_nxt;
      O_PREADY <= pready_nxt;
      O_PSLVERR <= pslverr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Command decode and sequencing
  // ----------------------------------------------------------------
  logic start_l, stop_l, dirsel_l, inch_l, mode_hi, cmd, cmd_dir, cmd_rise;
  logic start_prev_r, cmd_prev_r, inch_prev_r, tw_run_r, tw_run_nxt, tw_dir_r, tw_dir_nxt;
  logic dir_nxt, entering;
  logic [9:0] freq_nxt, inch_tgt;
  logic [7:0] volt_nxt, acc_r, acc_nxt;
  logic [19:0] sub_r, sub_nxt;
  always_comb begin
    start_l = term_hit(cfg_r.term_fn, FN_START, clean_r[NUM_TERM-1:0]); // see R2
    stop_l = term_hit(cfg_r.term_fn, FN_STOP, clean_r[NUM_TERM-1:0]); // see R2
    dirsel_l = term_hit(cfg_r.term_fn, FN_DIR, clean_r[NUM_TERM-1:0]); // see R2
    inch_l = term_hit(cfg_r.term_fn, FN_INCH, clean_r[NUM_TERM-1:0]); // see R7
    stop_asg = term_hit(cfg_r.term_fn, FN_STOP, '1);
    mode_hi = cfg_r.inch_mode >= MODE_FREE_HI && cfg_r.inch_mode <= MODE_DCB_HI;
    tw_run_nxt = tw_run_r;
    tw_dir_nxt = tw_dir_r;
    if (!stop_asg || !stop_l) begin
      tw_run_nxt = 1'b0; // see R4
    end else if (start_l && !start_prev_r && cfg_r.run_src == SRC_TERMINAL) begin
      tw_run_nxt = 1'b1; // see R1, R16
      tw_dir_nxt = dirsel_l; // see R16
    end
    cmd = stop_asg ? tw_run_r : (clean_r[IN_FWD] || clean_r[IN_REV]); // see R3
    cmd_dir = stop_asg ? tw_dir_r : (clean_r[IN_REV] && !clean_r[IN_FWD]);
    cmd_rise = cmd && !cmd_prev_r;
    state_nxt = state_r;
    stop_nxt = stop_r;
    unique case (state_r)
      ST_IDLE: begin
        if (cmd_rise) begin
          // Inch wins if it was up a cycle before the run command, or in modes 03 to 05 if it is up at all.
          state_nxt = (inch_l && (inch_prev_r || mode_hi)) ? ST_INCH : ST_RUN; // see R11
        end
      end
      ST_RUN: begin
        if (!cmd) begin
          state_nxt = ST_IDLE;
          stop_nxt = STOP_DECEL;
        end else if (mode_hi && inch_l && !inch_prev_r) begin
          state_nxt = ST_INCH; // see R10, R12
        end
      end
      ST_INCH: begin
        if (!cmd) begin
          state_nxt = ST_IDLE;
          stop_nxt = stop_kind(cfg_r.inch_mode); // see R9, R10
        end else if (!inch_l) begin
          state_nxt = ST_IDLE;
          stop_nxt = mode_hi ? STOP_FREE : stop_kind(cfg_r.inch_mode); // see R12
        end
      end
    endcase
    if (state_r == ST_IDLE && state_nxt != ST_IDLE) begin
      stop_nxt = STOP_NONE;
    end
    dir_nxt = (state_nxt == ST_IDLE) ? dir_r : cmd_dir;
    entering = state_r == ST_IDLE && state_nxt != ST_IDLE;
    inch_tgt = clamp_freq(cfg_r.inch_freq, cfg_r.init_freq); // see R8
    unique case (state_nxt)
      ST_IDLE: freq_nxt = 10'h000;
      ST_RUN: freq_nxt = entering ? cfg_r.init_freq
                                  : clamp_freq(cfg_r.run_freq, cfg_r.init_freq); // see R5
      ST_INCH: freq_nxt = entering ? cfg_r.init_freq : inch_tgt; // see R5, R8
    endcase
    // Soft ramp: volt steps once per ramp_sel sub ticks, reaching full in ramp_sel units.
    sub_nxt = 20'h00000;
    acc_nxt = 8'h00;
    volt_nxt = 8'h00;
    if (state_nxt == ST_INCH) begin
      volt_nxt = VOLT_FULL;
    end else if (state_nxt == ST_RUN) begin
      if (cfg_r.ramp_sel == RAMP_OFF) begin
        volt_nxt = VOLT_FULL; // see R6
      end else if (!entering) begin
        volt_nxt = volt_r;
        acc_nxt = acc_r;
        sub_nxt = sub_r + 20'h00001;
        if (volt_r == VOLT_FULL) begin
          sub_nxt = 20'h00000;
        end else if (sub_r == 20'(SUB_CYC - 1)) begin
          sub_nxt = 20'h00000;
          acc_nxt = acc_r + 8'h01;
          if (acc_nxt >= cfg_r.ramp_sel) begin
            acc_nxt = 8'h00;
            volt_nxt = volt_r + 8'h01; // see R6
          end
        end
      end
    end
  end
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      start_prev_r <= 1'b0;
      cmd_prev_r <= 1'b0;
      inch_prev_r <= 1'b0;
      tw_run_r <= 1'b0;
      tw_dir_r <= 1'b0;
      state_r <= ST_IDLE;
      stop_r <= STOP_NONE;
      dir_r <= 1'b0;
      freq_r <= 10'h000;
      volt_r <= 8'h00;
      acc_r <= 8'h00;
      sub_r <= 20'h00000;
      O_RUN <= 1'b0;
      O_DIR <= 1'b0;
      O_INCH <= 1'b0;
      O_FREQ <= 10'h000;
      O_VOLT <= 8'h00;
      O_FREE_RUN <= 1'b0;
      O_DECEL_STOP <= 1'b0;
      O_DC_BRAKE <= 1'b0;
      O_AUTO_BOOST <= 1'b0;
    end else begin
      start_prev_r <= start_l;
      cmd_prev_r <= cmd;
      inch_prev_r <= inch_l;
      tw_run_r <= tw_run_nxt;
      tw_dir_r <= tw_dir_nxt;
      state_r <= state_nxt;
      stop_r <= stop_nxt;
      dir_r <= dir_nxt;
      freq_r <= freq_nxt;
      volt_r <= volt_nxt;
      acc_r <= acc_nxt;
      sub_r <= sub_nxt;
      O_RUN <= state_nxt != ST_IDLE;
      O_DIR <= dir_nxt;
      O_INCH <= state_nxt == ST_INCH;
      O_FREQ <= freq_nxt;
      O_VOLT <= volt_nxt;
      O_FREE_RUN <= stop_nxt == STOP_FREE;
      O_DECEL_STOP <= stop_nxt == STOP_DECEL;
      O_DC_BRAKE <= stop_nxt == STOP_DCB;
      O_AUTO_BOOST <= cfg_r.boost == BOOST_AUTO; // see R15
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  stop_blocks_fwd_a: assert property ((state_r == ST_IDLE && stop_asg && !tw_run_r)
    |=> !O_RUN) else $error("run began from ignored forward input"); // see R3
  start_needs_stop_a: assert property (!stop_l |=> !tw_run_r)
    else $error("latched run without stop input"); // see R4
  first_freq_a: assert property ((state_r == ST_IDLE && state_nxt != ST_IDLE)
    |=> O_FREQ == $past(cfg_r.init_freq)) else $error("first frequency wrong"); // see R5
  ramp_off_full_a: assert property ((state_nxt == ST_RUN && cfg_r.ramp_sel == RAMP_OFF)
    |=> O_VOLT == VOLT_FULL) else $error("voltage not full with ramp off"); // see R6
  inch_freq_a: assert property ((state_r == ST_INCH && state_nxt == ST_INCH)
    |=> O_FREQ == $past(inch_tgt) && O_FREQ <= FREQ_MAX) else $error("inch freq"); // see R8
  inch_reject_a: assert property ((state_r == ST_RUN && !mode_hi)
    |=> state_r != ST_INCH) else $error("inch entered while running"); // see R9
  order_block_a: assert property ((state_r == ST_IDLE && cmd_rise && !inch_prev_r
    && !mode_hi) |=> O_RUN && !O_INCH) else $error("inch after late request"); // see R11
  early_drop_a: assert property ((state_r == ST_INCH && mode_hi && cmd && !inch_l)
    |=> O_FREE_RUN ##1 !O_INCH) else $error("no free run on early drop"); // see R12
  dcb_stop_a: assert property ((state_r == ST_INCH && !cmd && cfg_r.inch_mode == MODE_DCB_HI)
    |=> O_DC_BRAKE && !O_RUN) else $error("no DC brake stop"); // see R10
  boost_mode_a: assert property ($rose(cfg_r.boost == BOOST_AUTO) |=> O_AUTO_BOOST)
    else $error("auto boost flag missing"); // see R15
endmodule : drive_start_inch_seq
`default_nettype wire

// ---- logic/seq_pkg.sv ----
// Constants and types shared by the drive start and inch sequencer.
// Operation
// R1: Three-wire control works only when the run source selects the terminal block.
// R2: Terminal codes 20, 21, 22 give momentary start, momentary stop, direction.
// R3: Any terminal set to momentary stop makes forward and reverse inputs ignored.
// R4: Start is invalid while the stop input is inactive.
// R5: The first output frequency after a run command is the start frequency.
// R6: Ramp setting 00 disables the soft voltage start; 01 to 250 span 4 to 1000 ms.
// R7: Terminal code 06 makes that terminal the inch request input.
// R8: Inch outputs the inch frequency, limited between start frequency and 9.99 Hz.
// R9: Modes 00 to 02 reject inch while running; stop free, decelerated or DC brake.
// R10: Modes 03 to 05 allow inch while running; stop free, decelerated or DC brake.
// R11: Modes 00 to 02 give no inch when forward run comes before inch.
// R12: Modes 03 to 05 inch anyway; inch dropping before forward run gives free run.
// R13: The outside party raises inch before forward or reverse run.
// R14: Modes 02 and 05 need DC braking settings made beforehand.
// R15: Boost mode 01 selects automatic load-dependent boost instead of fixed boost.
// R16: A start edge with stop active latches run in the direction input's sense.
// R17: Terminals are synchronised and debounced before any edge or order check.
package seq_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int DEB_TIME_NS = 1000;
  localparam int DEB_CYC = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_UNIT_NS = 4000000;
  localparam int RAMP_UNIT_CYC = RAMP_UNIT_NS / CLK_PERIOD_NS;
  localparam int RAMP_STEPS = 256;
  localparam int NUM_TERM = 5;
  localparam int NUM_IN = 7;
  localparam int IN_FWD = 5;
  localparam int IN_REV = 6;
  localparam logic [7:0] FN_INCH = 8'h06;
  localparam logic [7:0] FN_START = 8'h14;
  localparam logic [7:0] FN_STOP = 8'h15;
  localparam logic [7:0] FN_DIR = 8'h16;
  localparam logic [7:0] SRC_TERMINAL = 8'h01;
  localparam logic [7:0] BOOST_AUTO = 8'h01;
  localparam logic [7:0] RAMP_OFF = 8'h00;
  localparam logic [7:0] MODE_FREE_HI = 8'h03;
  localparam logic [7:0] MODE_DECEL_LO = 8'h01;
  localparam logic [7:0] MODE_DCB_LO = 8'h02;
  localparam logic [7:0] MODE_DECEL_HI = 8'h04;
  localparam logic [7:0] MODE_DCB_HI = 8'h05;
  localparam logic [9:0] FREQ_MAX = 10'h3e7;
  localparam logic [7:0] VOLT_FULL = 8'hff;
  localparam logic [11:0] ADDR_TERM_A = 12'h000;
  localparam logic [11:0] ADDR_TERM_B = 12'h004;
  localparam logic [11:0] ADDR_MODE = 12'h008;
  localparam logic [11:0] ADDR_FREQ = 12'h00c;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [11:0] ADDR_OUT = 12'h014;
  localparam logic [11:0] ADDR_RUNF = 12'h018;
  localparam int POS_RUN_SRC = 8;
  localparam int POS_BOOST = 8;
  localparam int POS_RAMP = 16;
  localparam int POS_INCH_F = 16;
  localparam int POS_VOLT = 8;
  localparam int POS_INPUTS = 16;
  localparam logic [9:0] RST_INIT_F = 10'h032;
  localparam logic [9:0] RST_INCH_F = 10'h258;
  localparam logic [9:0] RST_RUN_F = 10'h1f4;

  typedef struct packed {
    logic [NUM_TERM-1:0][7:0] term_fn;
    logic [7:0] run_src;
    logic [7:0] inch_mode;
    logic [7:0] boost;
    logic [7:0] ramp_sel;
    logic [9:0] init_freq;
    logic [9:0] inch_freq;
    logic [9:0] run_freq;
  } cfg_t;

  localparam cfg_t RST_CFG = '{term_fn: '0, run_src: 8'h00, inch_mode: 8'h00,
    boost: 8'h00, ramp_sel: 8'h00, init_freq: RST_INIT_F, inch_freq: RST_INCH_F,
    run_freq: RST_RUN_F};

  typedef enum logic [1:0] {STOP_NONE, STOP_FREE, STOP_DECEL, STOP_DCB} stop_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_INCH} state_t;
endpackage : seq_pkg
